// file: msau_pkg.sv
// constants, types and shared decode for the memory space access unit
// assumes one system clock and an asynchronous active-high reset
`default_nettype none
package msau_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // program space
  localparam logic [23:0] MSAU_PC_RESET = 24'h00_0000;
  localparam logic [23:0] MSAU_START_VEC = 24'h00_0002;
  localparam logic [23:0] MSAU_IVT_LO = 24'h00_0004;
  localparam logic [23:0] MSAU_IVT_HI = 24'h00_00FF;
  localparam logic [23:0] MSAU_AIVT_LO = 24'h00_0100;
  localparam logic [23:0] MSAU_AIVT_HI = 24'h00_01FF;
  localparam logic [23:0] MSAU_PC_STEP = 24'h00_0002;

  ////////////////////////////////////////////////////////////////////////////
  // data space map
  localparam logic [15:0] MSAU_WREG_TOP = 16'h001F;
  localparam logic [15:0] MSAU_SFR_TOP = 16'h07FF;
  localparam logic [15:0] MSAU_RAM_BASE = 16'h0800;
  localparam logic [15:0] MSAU_DMA_BASE = 16'h1800;
  localparam logic [15:0] MSAU_NEAR_TOP = 16'h1FFF;
  localparam logic [15:0] MSAU_BYTE_STEP = 16'h0001;
  localparam logic [15:0] MSAU_WORD_STEP = 16'h0002;
  localparam logic [15:0] MSAU_WREG_RST = 16'h0000;
  localparam logic [15:0] MSAU_SP_RST = 16'h0800;
  localparam int MSAU_RAM_WORDS = 2048;
  localparam int MSAU_DMA_WORDS = 1024;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {MSAU_AM_DIRECT, MSAU_AM_NEAR, MSAU_AM_INDIRECT} msau_amode_type;
  typedef enum logic [1:0] {MSAU_VEC_NONE, MSAU_VEC_RESET, MSAU_VEC_PRIMARY,
                            MSAU_VEC_ALT} msau_vec_type;
  typedef enum logic [2:0] {MSAU_RG_WREG, MSAU_RG_SFR, MSAU_RG_RAM, MSAU_RG_DMA,
                            MSAU_RG_NONE, MSAU_RG_WINDOW} msau_region_type;

  ////////////////////////////////////////////////////////////////////////////
  // shared decode
  function automatic msau_region_type msau_region(input logic [15:0] ea);
    if (ea[15]) begin
      return MSAU_RG_WINDOW;
    end else if (ea <= MSAU_WREG_TOP) begin
      return MSAU_RG_WREG;
    end else if (ea <= MSAU_SFR_TOP) begin
      return MSAU_RG_SFR;
    end else if (ea < MSAU_DMA_BASE) begin
      return MSAU_RG_RAM;
    end else if (ea <= MSAU_NEAR_TOP) begin
      return MSAU_RG_DMA;
    end
    return MSAU_RG_NONE;
  endfunction : msau_region

  function automatic logic [15:0] msau_step(input logic [15:0] ptr, input logic byte_op);
    return ptr + (byte_op ? MSAU_BYTE_STEP : MSAU_WORD_STEP);
  endfunction : msau_step

  function automatic msau_vec_type msau_vec(input logic [23:0] addr);
    if (addr < MSAU_IVT_LO) begin
      return MSAU_VEC_RESET;
    end else if (addr <= MSAU_IVT_HI) begin
      return MSAU_VEC_PRIMARY;
    end else if (addr <= MSAU_AIVT_HI) begin
      return MSAU_VEC_ALT;
    end
    return MSAU_VEC_NONE;
  endfunction : msau_vec

endpackage : msau_pkg
`default_nettype wire

// file: msau_dma_if.sv
// signals between the access unit and its dual-ported dma ram
// assumes both ends run on the same clock
`default_nettype none
interface msau_dma_if;
  logic cpu_we;
  logic [1:0] cpu_be;
  logic [9:0] cpu_addr;
  logic [15:0] cpu_wdata;
  logic [15:0] cpu_rdata;
  logic dma_we;
  logic [9:0] dma_addr;
  logic [15:0] dma_wdata;
  logic [15:0] dma_rdata;
  logic collide;
  modport host (output cpu_we, cpu_be, cpu_addr, cpu_wdata, dma_we, dma_addr, dma_wdata,
                input cpu_rdata, dma_rdata, collide);
  modport ram (input cpu_we, cpu_be, cpu_addr, cpu_wdata, dma_we, dma_addr, dma_wdata,
               output cpu_rdata, dma_rdata, collide);
endinterface : msau_dma_if
`default_nettype wire

// file: msau_dma_ram.sv
// dual-ported dma ram, cpu port and dma port usable in the same cycle
// assumes the caller registers read data; reads here are combinational
`default_nettype none
module msau_dma_ram (
  input wire logic i_clk,
  input wire logic i_rst,
  msau_dma_if.ram bus
);
  import msau_pkg::*;

  logic [15:0] mem [MSAU_DMA_WORDS];
  logic dma_write;

  ////////////////////////////////////////////////////////////////////////////
  // read ports and collision detect
  assign bus.cpu_rdata = mem[bus.cpu_addr];
  assign bus.dma_rdata = mem[bus.dma_addr];
  assign bus.collide = bus.cpu_we && bus.dma_we && (bus.cpu_addr == bus.dma_addr);
  assign dma_write = bus.dma_we && !bus.collide;

  ////////////////////////////////////////////////////////////////////////////
  // cpu write precedence
  always_ff @(posedge i_clk) begin
    if (dma_write) begin
      mem[bus.dma_addr] <= bus.dma_wdata;
    end
    if (bus.cpu_we && bus.cpu_be[0]) begin
      mem[bus.cpu_addr][7:0] <= bus.cpu_wdata[7:0];
    end
    if (bus.cpu_we && bus.cpu_be[1]) begin
      mem[bus.cpu_addr][15:8] <= bus.cpu_wdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_collide_drop: assert property (bus.collide && bus.cpu_be == 2'b11
    |=> mem[$past(bus.cpu_addr)] == $past(bus.cpu_wdata))
    else $error("dma write not dropped on collision");
  chk_no_lost_dma: assert property (bus.dma_we && !bus.collide
    |=> mem[$past(bus.dma_addr)] == $past(bus.dma_wdata))
    else $error("dma write lost without collision");
  cov_collision: cover property (bus.collide);

endmodule : msau_dma_ram
`default_nettype wire

// file: msau_top.sv
// memory space access unit: program counter, program word view, data space
// decode with byte lanes, working registers, data ram and dma ram sharing
// assumes the core sequences instructions and takes the address trap itself
`default_nettype none
module msau_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PC_INC,
  input wire logic I_PC_DEC,
  input wire logic I_PC_LOAD,
  input wire logic [23:0] I_PC_TARGET,
  output logic [23:0] O_PC,
  input wire logic [23:0] I_PROG_ADDR,
  input wire logic [23:0] I_PROG_WORD,
  output logic [15:0] O_PROG_DATA,
  output msau_pkg::msau_vec_type O_VEC_REGION,
  input wire logic I_RD_EN,
  input wire msau_pkg::msau_amode_type I_RD_MODE,
  input wire logic [15:0] I_RD_ADDR,
  input wire logic I_RD_BYTE,
  output logic [15:0] O_RD_DATA,
  output logic O_RD_VALID,
  output logic O_RD_WINDOW,
  input wire logic I_WR_EN,
  input wire msau_pkg::msau_amode_type I_WR_MODE,
  input wire logic [15:0] I_WR_ADDR,
  input wire logic I_WR_BYTE,
  input wire logic [15:0] I_WR_DATA,
  output logic O_ADDR_TRAP,
  input wire logic [15:0] I_PTR_IN,
  input wire logic I_PTR_BYTE,
  output logic [15:0] O_PTR_NEXT,
  input wire logic I_WLD_EN,
  input wire logic [3:0] I_WLD_IDX,
  input wire logic [7:0] I_WLD_DATA,
  input wire logic I_EXT_EN,
  input wire logic I_EXT_SIGN,
  input wire logic [3:0] I_EXT_IDX,
  input wire logic I_DMA_WE,
  input wire logic [9:0] I_DMA_ADDR,
  input wire logic [15:0] I_DMA_WDATA,
  output logic [15:0] O_DMA_RDATA,
  output logic O_DMA_COLLIDE
);
  import msau_pkg::*;

  typedef struct packed {
    logic [23:0] pc;
    logic [15:0] prog;
    msau_vec_type vec;
    logic [15:0][15:0] wreg;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_win;
    logic trap;
    logic [15:0] ptr;
    logic [15:0] dma_rd;
    logic collide;
  } msau_state_type;

  msau_state_type s_q;
  msau_state_type s_d;
  logic [15:0] ram [MSAU_RAM_WORDS];
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  msau_region_type rd_rg;
  msau_region_type wr_rg;
  logic rd_misal;
  logic wr_misal;
  logic [1:0] wr_be;
  logic [15:0] wr_lanes;
  logic ram_we;
  logic [10:0] ram_wr_idx;
  logic [10:0] ram_rd_idx;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;

  msau_dma_if dma_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // effective address forms, one per address generation unit
  function automatic logic [15:0] form_ea(input msau_amode_type mode, input logic [15:0] addr,
                                          input logic [15:0][15:0] wreg);
    unique case (mode)
      MSAU_AM_NEAR: return {3'b000, addr[12:0]};
      MSAU_AM_INDIRECT: return wreg[addr[3:0]];
      default: return addr;
    endcase
  endfunction : form_ea

  // word index inside the general data ram
  function automatic logic [10:0] ram_index(input logic [15:0] ea);
    logic [11:0] w;
    w = ea[12:1] - MSAU_RAM_BASE[12:1];
    return w[10:0];
  endfunction : ram_index

  ////////////////////////////////////////////////////////////////////////////
  // independent read and write decode
  // near form and direct or indirect form
  assign rd_ea = form_ea(I_RD_MODE, I_RD_ADDR, s_q.wreg);
  assign wr_ea = form_ea(I_WR_MODE, I_WR_ADDR, s_q.wreg);
  assign rd_rg = msau_region(rd_ea);
  assign wr_rg = msau_region(wr_ea);
  assign rd_misal = I_RD_EN && !I_RD_BYTE && rd_ea[0];
  assign wr_misal = I_WR_EN && !I_WR_BYTE && wr_ea[0];
  assign ram_rd_idx = ram_index(rd_ea);
  assign ram_wr_idx = ram_index(wr_ea);

  ////////////////////////////////////////////////////////////////////////////
  // write lanes
  always_comb begin
    // one lane for a byte write, odd address is high lane
    if (!I_WR_EN) begin
      wr_be = 2'b00;
    end else if (I_WR_BYTE) begin
      wr_be = wr_ea[0] ? 2'b10 : 2'b01;
    end else begin
      wr_be = wr_misal ? 2'b00 : 2'b11;
    end
    wr_lanes = I_WR_BYTE ? {I_WR_DATA[7:0], I_WR_DATA[7:0]} : I_WR_DATA;
  end

  assign ram_we = (wr_rg == MSAU_RG_RAM) && (wr_be != 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // dma ram hookup; the cpu side never waits
  assign dma_bus.cpu_we = (wr_rg == MSAU_RG_DMA) && (wr_be != 2'b00);
  assign dma_bus.cpu_be = wr_be;
  // port goes to the read side unless a real cpu write is underway
  assign dma_bus.cpu_addr = dma_bus.cpu_we ? wr_ea[10:1] : rd_ea[10:1];
  assign dma_bus.cpu_wdata = wr_lanes;
  assign dma_bus.dma_we = I_DMA_WE;
  assign dma_bus.dma_addr = I_DMA_ADDR;
  assign dma_bus.dma_wdata = I_DMA_WDATA;

  msau_dma_ram u_dma_ram (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .bus(dma_bus.ram)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read word by region
  always_comb begin
    unique case (rd_rg)
      MSAU_RG_WREG: rd_word = s_q.wreg[rd_ea[4:1]];
      MSAU_RG_RAM: rd_word = ram[ram_rd_idx];
      // cpu read shares the port only when no cpu write targets dma ram
      MSAU_RG_DMA: rd_word = dma_bus.cpu_we ? 16'h0000 : dma_bus.cpu_rdata;
      // unused sfr space, unimplemented space, window handled outside
      default: rd_word = 16'h0000;
    endcase
    // pick byte by address bit 0
    rd_byte = rd_ea[0] ? rd_word[15:8] : rd_word[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    if (I_PC_LOAD) begin
      s_d.pc = {I_PC_TARGET[23:1], 1'b0};
    end else if (I_PC_INC) begin
      s_d.pc = s_q.pc + MSAU_PC_STEP;
    end else if (I_PC_DEC) begin
      s_d.pc = s_q.pc - MSAU_PC_STEP;
    end
    // lower word even, upper byte on odd with top byte zero
    s_d.prog = I_PROG_ADDR[0] ? {8'h00, I_PROG_WORD[23:16]} : I_PROG_WORD[15:0];
    s_d.vec = msau_vec(I_PROG_ADDR);
    // byte goes to low half; misaligned read still completes
    s_d.rd_valid = I_RD_EN;
    s_d.rd_data = I_RD_BYTE ? {8'h00, rd_byte} : rd_word;
    s_d.rd_win = I_RD_EN && (rd_rg == MSAU_RG_WINDOW);
    s_d.trap = rd_misal || wr_misal;
    s_d.ptr = msau_step(I_PTR_IN, I_PTR_BYTE);
    s_d.dma_rd = dma_bus.dma_rdata;
    s_d.collide = dma_bus.collide;
    if (wr_rg == MSAU_RG_WREG) begin
      if (wr_be[0]) begin
        s_d.wreg[wr_ea[4:1]][7:0] = wr_lanes[7:0];
      end
      if (wr_be[1]) begin
        s_d.wreg[wr_ea[4:1]][15:8] = wr_lanes[15:8];
      end
    end
    if (I_WLD_EN) begin
      s_d.wreg[I_WLD_IDX][7:0] = I_WLD_DATA;
    end
    if (I_EXT_EN) begin
      s_d.wreg[I_EXT_IDX][15:8] = I_EXT_SIGN ? {8{s_d.wreg[I_EXT_IDX][7]}} : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_q <= '0;
      s_q.pc <= MSAU_PC_RESET;
      s_q.vec <= MSAU_VEC_NONE;
      for (int i = 0; i < 15; i++) begin
        s_q.wreg[i] <= MSAU_WREG_RST;
      end
      s_q.wreg[15] <= MSAU_SP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general data ram, byte lanes
  always_ff @(posedge I_CLK) begin
    if (ram_we && wr_be[0]) begin
      ram[ram_wr_idx][7:0] <= wr_lanes[7:0];
    end
    if (ram_we && wr_be[1]) begin
      ram[ram_wr_idx][15:8] <= wr_lanes[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign O_PC = s_q.pc;
  assign O_PROG_DATA = s_q.prog;
  assign O_VEC_REGION = s_q.vec;
  assign O_RD_DATA = s_q.rd_data;
  assign O_RD_VALID = s_q.rd_valid;
  assign O_RD_WINDOW = s_q.rd_win;
  assign O_ADDR_TRAP = s_q.trap;
  assign O_PTR_NEXT = s_q.ptr;
  assign O_DMA_RDATA = s_q.dma_rd;
  assign O_DMA_COLLIDE = s_q.collide;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  chk_pc_even_always: assert property (O_PC[0] == 1'b0)
    else $error("program counter odd");
  chk_pc_step_two: assert property (I_PC_INC && !I_PC_LOAD
    |=> O_PC == $past(O_PC) + 24'h00_0002)
    else $error("program counter step not two");
  chk_pc_start_zero: assert property ($past(I_RST) |-> O_PC == 24'h00_0000)
    else $error("program counter not zero after reset");
  chk_prog_upper_byte: assert property (I_PROG_ADDR[0] |=> O_PROG_DATA[15:8] == 8'h00)
    else $error("upper program byte not zero");
  chk_vec_alt_table: assert property (I_PROG_ADDR >= 24'h00_0100
    && I_PROG_ADDR <= 24'h00_01FF |=> O_VEC_REGION == MSAU_VEC_ALT)
    else $error("alternate vector table not tagged");
  chk_unimpl_read_zero: assert property (I_RD_EN && rd_ea[15:13] != 3'b000
    |=> O_RD_DATA == 16'h0000)
    else $error("unimplemented read not zero");
  chk_byte_read_low: assert property (I_RD_EN && I_RD_BYTE |=> O_RD_DATA[15:8] == 8'h00)
    else $error("byte read high half not zero");
  chk_trap_word_odd: assert property (I_WR_EN && !I_WR_BYTE && wr_ea[0]
    |-> !ram_we && !dma_bus.cpu_we ##1 O_ADDR_TRAP)
    else $error("misaligned write not suppressed or no trap");
  chk_trap_cause: assert property (O_ADDR_TRAP |-> $past(rd_misal || wr_misal))
    else $error("trap without misaligned word access");
  chk_ptr_scaled: assert property (I_PTR_BYTE |=> O_PTR_NEXT == $past(I_PTR_IN) + 16'h0001)
    else $error("byte pointer step not one");
  chk_wld_keeps_high: assert property (I_WLD_EN && !I_EXT_EN
    && !(I_WR_EN && wr_rg == MSAU_RG_WREG)
    |=> s_q.wreg[$past(I_WLD_IDX)][15:8] == $past(s_q.wreg[I_WLD_IDX][15:8]))
    else $error("byte load changed high byte");
  chk_sfr_unused_zero: assert property (I_RD_EN && rd_rg == MSAU_RG_SFR
    |=> O_RD_DATA == 16'h0000)
    else $error("unused sfr read not zero");

  cov_byte_read_odd: cover property (I_RD_EN && I_RD_BYTE && rd_ea[0]);
  cov_misaligned_trap: cover property (O_ADDR_TRAP);
  cov_dma_collision: cover property (O_DMA_COLLIDE);
  cov_pc_load: cover property (I_PC_LOAD ##1 I_PC_INC);

endmodule : msau_top
`default_nettype wire

// file: msau_dma_model.sv
// behavioural dma controller driving the dma port of the access unit
// assumes one shared clock; requests launched just after a rising edge
`default_nettype none
module msau_dma_model (
  input wire logic i_clk,
  output logic o_we,
  output logic [9:0] o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_we = 1'b0;
    o_addr = 10'h3FF;
    o_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one dma access after an idle edge, held for one edge, then port released
  // no stall assumed
  task automatic put(input logic we, input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_we = we;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_we = 1'b0;
    o_addr = ~a;  // released port shows no stale value
    o_wdata = ~d;
  endtask : put
endmodule : msau_dma_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the memory space access unit
// assumes msau_pkg, msau_dma_if and the design files are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import msau_pkg::*;

  typedef struct {
    logic [15:0] wa;
    logic wb;
    logic [15:0] wd;
    logic [15:0] ra;
    logic rb;
    logic [15:0] ex;
  } msau_row_type;

  logic I_CLK = 1'b0, I_RST = 1'b1;
  logic I_PC_INC = 1'b0, I_PC_DEC = 1'b0, I_PC_LOAD = 1'b0;
  logic [23:0] I_PC_TARGET = 24'h00_0000, I_PROG_ADDR = 24'h00_0000, I_PROG_WORD = 24'h00_0000;
  logic [23:0] O_PC;
  logic [15:0] O_PROG_DATA, O_RD_DATA, O_PTR_NEXT, O_DMA_RDATA;
  msau_vec_type O_VEC_REGION;
  logic I_RD_EN = 1'b0, I_RD_BYTE = 1'b0, I_WR_EN = 1'b0, I_WR_BYTE = 1'b0;
  msau_amode_type I_RD_MODE = MSAU_AM_DIRECT, I_WR_MODE = MSAU_AM_DIRECT;
  logic [15:0] I_RD_ADDR = 16'h0000, I_WR_ADDR = 16'h0000, I_WR_DATA = 16'h0000;
  logic [15:0] I_PTR_IN = 16'h0000;
  logic I_PTR_BYTE = 1'b0, I_WLD_EN = 1'b0, I_EXT_EN = 1'b0, I_EXT_SIGN = 1'b0;
  logic [3:0] I_WLD_IDX = 4'h0, I_EXT_IDX = 4'h0;
  logic [7:0] I_WLD_DATA = 8'h00;
  logic O_RD_VALID, O_RD_WINDOW, O_ADDR_TRAP, O_DMA_COLLIDE;
  logic dma_we;
  logic [9:0] dma_addr;
  logic [15:0] dma_wdata;
  int err_count = 0;
  int tests_run = 0;
  msau_row_type rows[8] = '{
    '{16'h0800, 1'b0, 16'hA5C3, 16'h0800, 1'b0, 16'hA5C3},
    '{16'h0801, 1'b1, 16'h00AB, 16'h0800, 1'b0, 16'hABC3},
    '{16'h0802, 1'b1, 16'h0011, 16'h0801, 1'b1, 16'h00AB},
    '{16'h0803, 1'b1, 16'h0022, 16'h0802, 1'b0, 16'h2211},
    '{16'h0040, 1'b0, 16'hFFFF, 16'h0040, 1'b0, 16'h0000},
    '{16'h2000, 1'b0, 16'hFFFF, 16'h2000, 1'b0, 16'h0000},
    '{16'h0004, 1'b0, 16'h1234, 16'h0004, 1'b0, 16'h1234},
    '{16'h1806, 1'b0, 16'hBEEF, 16'h1806, 1'b0, 16'hBEEF}};
  logic [23:0] vec_addr[6] = '{24'h00_0000, 24'h00_0004, 24'h00_00FF,
                               24'h00_0100, 24'h00_01FF, 24'h00_0200};
  msau_vec_type vec_exp[6] = '{MSAU_VEC_RESET, MSAU_VEC_PRIMARY, MSAU_VEC_PRIMARY,
                               MSAU_VEC_ALT, MSAU_VEC_ALT, MSAU_VEC_NONE};

  // free-running system clock
  always #5 I_CLK = ~I_CLK;

  msau_top dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_PC_INC(I_PC_INC), .I_PC_DEC(I_PC_DEC),
    .I_PC_LOAD(I_PC_LOAD), .I_PC_TARGET(I_PC_TARGET), .O_PC(O_PC), .I_PROG_ADDR(I_PROG_ADDR),
    .I_PROG_WORD(I_PROG_WORD), .O_PROG_DATA(O_PROG_DATA), .O_VEC_REGION(O_VEC_REGION),
    .I_RD_EN(I_RD_EN), .I_RD_MODE(I_RD_MODE), .I_RD_ADDR(I_RD_ADDR), .I_RD_BYTE(I_RD_BYTE),
    .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID), .O_RD_WINDOW(O_RD_WINDOW),
    .I_WR_EN(I_WR_EN), .I_WR_MODE(I_WR_MODE), .I_WR_ADDR(I_WR_ADDR), .I_WR_BYTE(I_WR_BYTE),
    .I_WR_DATA(I_WR_DATA), .O_ADDR_TRAP(O_ADDR_TRAP), .I_PTR_IN(I_PTR_IN),
    .I_PTR_BYTE(I_PTR_BYTE), .O_PTR_NEXT(O_PTR_NEXT), .I_WLD_EN(I_WLD_EN),
    .I_WLD_IDX(I_WLD_IDX), .I_WLD_DATA(I_WLD_DATA), .I_EXT_EN(I_EXT_EN),
    .I_EXT_SIGN(I_EXT_SIGN), .I_EXT_IDX(I_EXT_IDX), .I_DMA_WE(dma_we),
    .I_DMA_ADDR(dma_addr), .I_DMA_WDATA(dma_wdata), .O_DMA_RDATA(O_DMA_RDATA),
    .O_DMA_COLLIDE(O_DMA_COLLIDE));

  msau_dma_model dm (.i_clk(I_CLK), .o_we(dma_we), .o_addr(dma_addr), .o_wdata(dma_wdata));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic cyc();
    @(posedge I_CLK);
    #1;
  endtask : cyc

  task automatic chk_val(input logic [23:0] got, input logic [23:0] ex, input string what);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %0t %s got %h want %h", $time, what, got, ex);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic ex, input string what);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %0t %s flag %b", $time, what, got);
    end
  endtask : chk_flag

  task automatic wr(input msau_amode_type m, input logic [15:0] a, input logic b,
                    input logic [15:0] d);
    cyc();  // idle edge between requests
    I_WR_MODE = m;
    I_WR_ADDR = a;
    I_WR_BYTE = b;
    I_WR_DATA = d;
    I_WR_EN = 1'b1;
    cyc();
    I_WR_EN = 1'b0;
  endtask : wr

  task automatic rd(input msau_amode_type m, input logic [15:0] a, input logic b);
    cyc();  // idle edge between requests
    I_RD_MODE = m;
    I_RD_ADDR = a;
    I_RD_BYTE = b;
    I_RD_EN = 1'b1;
    cyc();
    I_RD_EN = 1'b0;
  endtask : rd

  task automatic pc_op(input logic inc, input logic dec, input logic ld, input logic [23:0] t);
    cyc();  // idle edge between requests
    {I_PC_INC, I_PC_DEC, I_PC_LOAD, I_PC_TARGET} = {inc, dec, ld, t};
    cyc();
    {I_PC_INC, I_PC_DEC, I_PC_LOAD} = 3'b000;
  endtask : pc_op

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung run
  initial begin
    #20000;
    err_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) cyc();
    I_RST = 1'b0;
    chk_val(O_PC, 24'h00_0000, "pc reset");
    rd(MSAU_AM_DIRECT, 16'h001E, 1'b0);
    chk_val(O_RD_DATA, 16'h0800, "reg15 reset");
    // table of write then read cases
    foreach (rows[i]) begin
      wr(MSAU_AM_DIRECT, rows[i].wa, rows[i].wb, rows[i].wd);
      rd(MSAU_AM_DIRECT, rows[i].ra, rows[i].rb);
      chk_val(O_RD_DATA, rows[i].ex, "row");
      chk_flag(O_RD_VALID, 1'b1, "valid");
    end
    // program counter steps and load alignment
    pc_op(1'b1, 1'b0, 1'b0, 24'h00_0000);
    pc_op(1'b1, 1'b0, 1'b0, 24'h00_0000);
    chk_val(O_PC, 24'h00_0004, "pc inc");
    pc_op(1'b0, 1'b1, 1'b0, 24'h00_0000);
    chk_val(O_PC, 24'h00_0002, "pc dec");
    pc_op(1'b0, 1'b0, 1'b1, 24'h00_0101);
    chk_val(O_PC, 24'h00_0100, "pc load");
    // program word halves and vector regions
    I_PROG_WORD = 24'h12_3456;
    I_PROG_ADDR = 24'h00_0010;
    cyc();
    chk_val(O_PROG_DATA, 16'h3456, "prog low");
    I_PROG_ADDR = 24'h00_0011;
    cyc();
    chk_val(O_PROG_DATA, 16'h0012, "prog high");
    foreach (vec_addr[i]) begin
      I_PROG_ADDR = vec_addr[i];
      cyc();
      chk_val(O_VEC_REGION, vec_exp[i], "vector");
    end
    // pointer post-increment scaling
    I_PTR_IN = 16'hFFFF;
    I_PTR_BYTE = 1'b1;
    cyc();
    chk_val(O_PTR_NEXT, 16'h0000, "ptr byte");
    I_PTR_IN = 16'h0800;
    I_PTR_BYTE = 1'b0;
    cyc();
    chk_val(O_PTR_NEXT, 16'h0802, "ptr word");
    // misaligned word write and read
    wr(MSAU_AM_DIRECT, 16'h0801, 1'b0, 16'hFFFF);
    chk_flag(O_ADDR_TRAP, 1'b1, "trap wr");
    rd(MSAU_AM_DIRECT, 16'h0801, 1'b0);
    chk_flag(O_ADDR_TRAP, 1'b1, "trap rd");
    chk_val(O_RD_DATA, 16'hABC3, "misaligned");
    rd(MSAU_AM_DIRECT, 16'h0800, 1'b0);
    chk_flag(O_ADDR_TRAP, 1'b0, "no trap");
    // window, near field and indirect forms
    rd(MSAU_AM_DIRECT, 16'h8000, 1'b0);
    chk_flag(O_RD_WINDOW, 1'b1, "window");
    chk_val(O_RD_DATA, 16'h0000, "window data");
    rd(MSAU_AM_NEAR, 16'hE800, 1'b0);
    chk_val(O_RD_DATA, 16'hABC3, "near");
    wr(MSAU_AM_DIRECT, 16'h0006, 1'b0, 16'h0800);
    rd(MSAU_AM_INDIRECT, 16'h0003, 1'b0);
    chk_val(O_RD_DATA, 16'hABC3, "indirect");
    // byte load then sign and zero extend of reg2
    {I_WLD_EN, I_WLD_IDX, I_WLD_DATA} = {1'b1, 4'h2, 8'h85};
    cyc();
    I_WLD_EN = 1'b0;
    rd(MSAU_AM_DIRECT, 16'h0004, 1'b0);
    chk_val(O_RD_DATA, 16'h1285, "byte load");
    {I_EXT_EN, I_EXT_SIGN, I_EXT_IDX} = {1'b1, 1'b1, 4'h2};
    cyc();
    I_EXT_EN = 1'b0;
    rd(MSAU_AM_DIRECT, 16'h0004, 1'b0);
    chk_val(O_RD_DATA, 16'hFF85, "sign ext");
    {I_EXT_EN, I_EXT_SIGN} = {1'b1, 1'b0};
    cyc();
    I_EXT_EN = 1'b0;
    rd(MSAU_AM_DIRECT, 16'h0004, 1'b0);
    chk_val(O_RD_DATA, 16'h0085, "zero ext");
    // simultaneous cpu and dma access, then same-word write collision
    fork
      dm.put(1'b0, 10'h003, 16'h0000);
      rd(MSAU_AM_DIRECT, 16'h1806, 1'b0);
    join
    chk_val(O_DMA_RDATA, 16'hBEEF, "dma read");
    chk_val(O_RD_DATA, 16'hBEEF, "cpu read");
    fork
      dm.put(1'b1, 10'h002, 16'h2222);
      wr(MSAU_AM_DIRECT, 16'h1804, 1'b0, 16'h1111);
    join
    chk_flag(O_DMA_COLLIDE, 1'b1, "collide");
    rd(MSAU_AM_DIRECT, 16'h1804, 1'b0);
    chk_val(O_RD_DATA, 16'h1111, "cpu wins");
    dm.put(1'b1, 10'h005, 16'h5A5A);
    chk_flag(O_DMA_COLLIDE, 1'b0, "no collide");
    rd(MSAU_AM_DIRECT, 16'h180A, 1'b0);
    chk_val(O_RD_DATA, 16'h5A5A, "dma write");
    // second reset in mid-run
    I_RST = 1'b1;
    cyc();
    I_RST = 1'b0;
    chk_val(O_PC, 24'h00_0000, "pc rerun");
    rd(MSAU_AM_DIRECT, 16'h0004, 1'b0);
    chk_val(O_RD_DATA, 16'h0000, "reg reset");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
